// ==== rtl/power_down_and_reset_sequencer.v ====
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
// Operation
// [R1] writing sleep code halts cpu clock
// [R2] stop needs unlock code then stop instruction
// [R3] sleep keeps oscillators and peripheral clock
// [R4] sleep exits on reset or enabled interrupt
// [R5] stop halts main osc, system, peripheral clocks
// [R6] stop retains ram, registers and ports
// [R7] stop halts interval timer, timers unless counting
// [R8] stop gates peripherals except watch, booster
// [R9] stop grounds main oscillator input internally
// [R10] stop exits only on listed wake sources
// [R11] software enables wake interrupt before stop
// [R12] reset reinitialises registers, interrupt wake preserves; a stop wake clears power_down_control
// [R13] stop exit waits out oscillator stabilisation
// [R14] software programs stabilisation above minimum
// [R15] software puts two nops after stop
// [R16] reset pin low minimum oscillator periods
// [R17] reset release waits delay plus periods
// [R18] execution starts from reset vector pair
// [R19] reset clears page, flag, sets main clock
// [R20] pin and watchdog reset act alike
// [R21] clock mode register resets to zero
// [R22] stop without unlock code is ignored
module power_down_and_reset_sequencer #(
  parameter [23:0] STAB_DELAY_CYC = `STAB_DELAY_CYC,
  parameter [23:0] STOP_STAB_CYC  = `STOP_STAB_CYC
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdData,
  input  wire        stopInstr,
  input  wire        resetPinN,
  input  wire        watchdogReset,
  input  wire        oscStable,
  input  wire        extClockUsed,
  input  wire [3:0]  wakeRequest,
  input  wire [3:0]  wakeEnable,
  input  wire        anyIrqPending,
  input  wire [1:0]  eventCounterMode,
  output reg         cpuClkEn,
  output reg         periClkEn,
  output reg         mainOscEn,
  output reg         mainOscInputTieLow,
  output reg         subOscEn,
  output reg         watchClkEn,
  output reg         boosterClkEn,
  output reg         intervalTimerRun,
  output reg  [1:0]  timerRun,
  output reg         retainState,
  output reg         ctrlRegInit,
  output reg         cpuRun,
  output reg  [15:0] vectorAddr,
  output reg  [7:0]  ramPageSelect,
  output reg         directPageFlag,
  output reg         supplyDropMonitorEn,
  output reg         boosterEn
);
  ////////////////////////////////////////////////////////////////////
  // states
  localparam [5:0] ST_RESET = 6'h01;  // reset held
  localparam [5:0] ST_WAIT  = 6'h02;  // post-reset stabilisation
  localparam [5:0] ST_RUN   = 6'h04;  // main active
  localparam [5:0] ST_SLEEP = 6'h08;  // cpu clock off
  localparam [5:0] ST_STOP  = 6'h10;  // all clocks off but sub osc, watch and booster
  localparam [5:0] ST_START = 6'h20;  // stop exit start-up

  reg [5:0] state_ff;         // current state
  reg [5:0] nxt_state;        // next state
  reg [7:0] powerDownCtl_ff;  // power_down_control register
  reg [7:0] intervalCtl_ff;   // interval_timer_control register
  reg [7:0] clockMode_ff;     // clock_mode_select register
  reg       postCnt_ff;       // second phase of post-reset wait
  reg       loadCnt;          // restart the shared counter
  reg [23:0] loadValue;       // counter reload value
  wire      cntDone;          // counter reached zero
  wire      pinReset;         // filtered external reset
  wire      anyReset;         // either reset source
  wire [3:0] stopWake;        // enabled stop wake sources
  wire [31:0] postResetCyc;   // post-reset count at full integer width

  // held wide so the counter load cuts it on purpose
  assign postResetCyc = `POST_RESET_CYC;

  ////////////////////////////////////////////////////////////////////
  // reset sources
  pwr_reset_filter u_filter (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .resetPinN (resetPinN),
    .oscStable (oscStable),
    .resetSeen (pinReset)
  );

  // both sources share one initialisation path
  assign anyReset = pinReset | watchdogReset;  // [R20] [R16]

  // only enabled stop-capable sources release stop
  assign stopWake = wakeRequest & wakeEnable;  // [R10] [R11]

  pwr_down_counter u_count (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .load      (loadCnt),
    .loadValue (loadValue),
    .done      (cntDone)
  );

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always @* begin
    nxt_state = state_ff;
    loadCnt   = 1'b0;
    loadValue = STAB_DELAY_CYC;
    case (state_ff)
      ST_RESET: begin
        // hold until pin high and watchdog quiet
        if (!anyReset && resetPinN) begin
          nxt_state = ST_WAIT;
          loadCnt   = 1'b1;  // [R17]
        end
      end
      ST_WAIT: begin
        if (anyReset) begin
          nxt_state = ST_RESET;
        end else if (cntDone && !postCnt_ff) begin
          loadCnt   = 1'b1;
          loadValue = postResetCyc[23:0];  // [R17]
        end else if (cntDone && postCnt_ff && !loadCnt) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (anyReset) begin
          nxt_state = ST_RESET;
        end else if (stopInstr && powerDownCtl_ff == `CODE_STOP_UNLOCK
                     && !extClockUsed) begin
          nxt_state = ST_STOP;  // [R2] [R9]
        end else if (regWrite && regAddr == `ADDR_POWER_DOWN_CONTROL
                     && regWrData == `CODE_SLEEP) begin
          nxt_state = ST_SLEEP;  // [R1]
        end
        // stop without the unlock code simply stays in run  [R22]
      end
      ST_SLEEP: begin
        if (anyReset) begin
          nxt_state = ST_RESET;
        end else if (anyIrqPending) begin
          nxt_state = ST_RUN;  // [R4]
        end
      end
      ST_STOP: begin
        if (anyReset) begin
          nxt_state = ST_RESET;  // [R12]
        end else if (stopWake != 4'h0) begin
          nxt_state = ST_START;
          loadCnt   = 1'b1;
          loadValue = (intervalCtl_ff == 8'h00) ? STOP_STAB_CYC
                      : {intervalCtl_ff, 16'h0000};  // [R13]
        end
      end
      ST_START: begin
        if (anyReset) begin
          nxt_state = ST_RESET;
        end else if (cntDone) begin
          nxt_state = ST_RUN;  // [R13]
        end
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register and post-reset phase
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_RESET;
      postCnt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_WAIT && cntDone && !postCnt_ff) begin
        postCnt_ff <= 1'b1;
      end else if (state_ff != ST_WAIT) begin
        postCnt_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers; reset reinitialises them, interrupt wake leaves them but a stop wake clears power_down_control
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerDownCtl_ff <= `RST_POWER_DOWN_CONTROL;
      intervalCtl_ff  <= `RST_INTERVAL_TIMER_CTL;
      clockMode_ff    <= `RST_CLOCK_MODE_SELECT;
    end else if (state_ff == ST_RESET) begin
      powerDownCtl_ff <= `RST_POWER_DOWN_CONTROL;  // [R12] [R21]
      intervalCtl_ff  <= `RST_INTERVAL_TIMER_CTL;
      clockMode_ff    <= `RST_CLOCK_MODE_SELECT;
    end else if (regWrite && state_ff == ST_RUN) begin
      // unlock code is consumed when a wake source ends stop
      case (regAddr)
        `ADDR_POWER_DOWN_CONTROL: powerDownCtl_ff <= regWrData;
        `ADDR_INTERVAL_TIMER_CTL: intervalCtl_ff  <= regWrData;
        `ADDR_CLOCK_MODE_SELECT:  clockMode_ff    <= regWrData;
        default: begin
        end
      endcase
    end else if (state_ff == ST_STOP && nxt_state == ST_START) begin
      powerDownCtl_ff <= `RST_POWER_DOWN_CONTROL;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port, data valid the cycle after the strobe
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_POWER_DOWN_CONTROL: regRdData <= powerDownCtl_ff;
        `ADDR_INTERVAL_TIMER_CTL: regRdData <= intervalCtl_ff;
        `ADDR_CLOCK_MODE_SELECT:  regRdData <= clockMode_ff;
        `ADDR_STATUS:             regRdData <= {2'b00, state_ff};
        default:                  regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock gating and reset outputs, all registered
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuClkEn            <= 1'b0;
      periClkEn           <= 1'b1;
      mainOscEn           <= 1'b1;
      mainOscInputTieLow  <= 1'b0;
      subOscEn            <= 1'b1;
      watchClkEn          <= 1'b1;
      boosterClkEn        <= 1'b1;
      intervalTimerRun    <= 1'b1;
      timerRun            <= 2'b11;
      retainState         <= 1'b0;
      ctrlRegInit         <= 1'b1;
      cpuRun              <= 1'b0;
      vectorAddr          <= `RESET_VECTOR_LO;
      ramPageSelect       <= `RST_RAM_PAGE;
      directPageFlag      <= 1'b0;
      supplyDropMonitorEn <= 1'b0;
      boosterEn           <= 1'b0;
    end else begin
      // sleep only stops the cpu clock  [R3]
      cpuClkEn   <= (nxt_state == ST_RUN);  // [R1]
      cpuRun     <= (nxt_state == ST_RUN);  // [R13] [R17]
      subOscEn   <= 1'b1;  // [R5]
      watchClkEn <= 1'b1;  // [R8]
      boosterClkEn <= 1'b1;  // [R8]
      // start-up keeps peripherals frozen too
      periClkEn  <= !(nxt_state == ST_STOP || nxt_state == ST_START);  // [R5] [R8]
      mainOscEn  <= (nxt_state != ST_STOP);  // [R5]
      mainOscInputTieLow <= (nxt_state == ST_STOP);  // [R9]
      intervalTimerRun   <= (nxt_state != ST_STOP && nxt_state != ST_START);  // [R7]
      timerRun[0] <= (nxt_state != ST_STOP && nxt_state != ST_START)
                     || eventCounterMode[0];  // [R7]
      timerRun[1] <= (nxt_state != ST_STOP && nxt_state != ST_START)
                     || eventCounterMode[1];  // [R7]
      retainState <= (nxt_state == ST_STOP || nxt_state == ST_START);  // [R6]
      ctrlRegInit <= (nxt_state == ST_RESET);  // [R12] [R20]
      vectorAddr  <= `RESET_VECTOR_LO;  // [R18]
      if (nxt_state == ST_RESET) begin
        ramPageSelect       <= `RST_RAM_PAGE;  // [R19]
        directPageFlag      <= 1'b0;  // [R19]
        supplyDropMonitorEn <= 1'b0;  // [R19]
        boosterEn           <= 1'b0;  // [R19]
      end
    end
  end
endmodule

// ==== rtl/pwr_down_counter.v ====
`timescale 1ns/1ns
// loadable down counter; done is high while the count is zero
module pwr_down_counter (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        load,
  input  wire [23:0] loadValue,
  output wire        done
);
  reg [23:0] count_ff;  // remaining cycles

  // load wins over counting so a restart never skips cycles
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 24'h000000;
    end else if (load) begin
      count_ff <= loadValue;
    end else if (count_ff != 24'h000000) begin
      count_ff <= count_ff - 24'h000001;
    end
  end

  assign done = (count_ff == 24'h000000);
endmodule

// ==== rtl/pwr_reset_filter.v ====
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
// accepts the reset pin only after it stays low for the minimum time
module pwr_reset_filter (
  input  wire core_clk,
  input  wire rst_n,
  input  wire resetPinN,
  input  wire oscStable,
  output reg  resetSeen
);
  reg [7:0] lowCount_ff;  // consecutive low cycles

  // a short glitch or a low pin with an unstable oscillator restarts the count
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCount_ff <= 8'h00;
      resetSeen   <= 1'b0;
    end else if (resetPinN || !oscStable) begin
      lowCount_ff <= 8'h00;
      resetSeen   <= 1'b0;
    end else if (lowCount_ff < `RESET_MIN_CYC) begin
      lowCount_ff <= lowCount_ff + 8'h01;
      resetSeen   <= (lowCount_ff == `RESET_MIN_CYC - 1);
    end else begin
      resetSeen   <= 1'b1;
    end
  end
endmodule

// ==== rtl/pwr_seq_defines.vh ====
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH
// register map
`define ADDR_POWER_DOWN_CONTROL 8'he9
`define ADDR_INTERVAL_TIMER_CTL 8'hec
`define ADDR_CLOCK_MODE_SELECT  8'hed
`define ADDR_STATUS             8'hee
// control codes
`define CODE_SLEEP              8'h0f
`define CODE_STOP_UNLOCK        8'h5a
// reset values
`define RST_POWER_DOWN_CONTROL  8'h00
`define RST_INTERVAL_TIMER_CTL  8'h00
`define RST_CLOCK_MODE_SELECT   8'h00
`define RST_RAM_PAGE            8'h00
// reset vector pair at the top of memory
`define RESET_VECTOR_LO         16'hfffe
`define RESET_VECTOR_HI         16'hffff
// wake source bit positions
`define WAKE_EXT                0
`define WAKE_WATCH              1
`define WAKE_KEY                2
`define WAKE_EVENT              3
// timing
`define CLK_PERIOD_NS           10
`define OSC_PERIOD_NS           250
`define RESET_MIN_OSC           8
`define RESET_MIN_CYC           ((`RESET_MIN_OSC*`OSC_PERIOD_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define POST_RESET_OSC          7
`define POST_RESET_CYC          ((`POST_RESET_OSC*`OSC_PERIOD_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define STAB_DELAY_US           65500
`define STAB_DELAY_CYC          ((`STAB_DELAY_US*1000)/`CLK_PERIOD_NS)
`define STOP_STAB_MIN_US        20000
`define STOP_STAB_CYC           ((`STOP_STAB_MIN_US*1000)/`CLK_PERIOD_NS)
`endif

// ==== testbench/power_down_and_reset_sequencer_bench.sv ====
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t %s", $time, m); end end
module power_down_and_reset_sequencer_bench;
  reg        core_clk, rst_n, regWrite, regRead, resetPinN, watchdogReset, oscStable;
  reg        extClockUsed, anyIrqPending, execStop;
  reg  [7:0] regAddr, regWrData, v;
  reg  [3:0] wakeRequest, wakeEnable;
  reg  [1:0] eventCounterMode;
  wire [7:0] regRdData, ramPageSelect;
  wire [1:0] timerRun;
  wire [15:0] vectorAddr;
  wire       stopInstr, cpuClkEn, periClkEn, mainOscEn, mainOscInputTieLow, subOscEn, watchClkEn;
  wire       boosterClkEn, intervalTimerRun, retainState, ctrlRegInit, cpuRun, directPageFlag;
  wire       supplyDropMonitorEn, boosterEn;
  integer    miscompares = 0, total_checks = 0, expMode, n;
  int        srcQ[$] = '{0, 1, 2, 3}; // wake sources still to try
  // short stabilisation counts keep the run brief
  power_down_and_reset_sequencer #(.STAB_DELAY_CYC(24'd20), .STOP_STAB_CYC(24'd10)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .stopInstr(stopInstr),
    .resetPinN(resetPinN), .watchdogReset(watchdogReset), .oscStable(oscStable),
    .extClockUsed(extClockUsed), .wakeRequest(wakeRequest), .wakeEnable(wakeEnable),
    .anyIrqPending(anyIrqPending), .eventCounterMode(eventCounterMode), .cpuClkEn(cpuClkEn),
    .periClkEn(periClkEn), .mainOscEn(mainOscEn), .mainOscInputTieLow(mainOscInputTieLow),
    .subOscEn(subOscEn), .watchClkEn(watchClkEn), .boosterClkEn(boosterClkEn),
    .intervalTimerRun(intervalTimerRun), .timerRun(timerRun), .retainState(retainState),
    .ctrlRegInit(ctrlRegInit), .cpuRun(cpuRun), .vectorAddr(vectorAddr),
    .ramPageSelect(ramPageSelect), .directPageFlag(directPageFlag),
    .supplyDropMonitorEn(supplyDropMonitorEn), .boosterEn(boosterEn));
  pwr_cpu_partner cpu (.core_clk(core_clk), .rst_n(rst_n), .cpuRun(cpuRun),
    .execStop(execStop), .stopInstr(stopInstr));
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task tick(input integer k);
    repeat (k) @(posedge core_clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 `CHK(regRdData, e, "read data")
  endtask
  // cycles until the cpu runs, bounded so a hang cannot stall here;
  // looks 1 ns after each edge so the registered output has settled
  task waitCpu;
    n = 0;
    while (cpuRun !== 1'b1 && n < 400) begin @(posedge core_clk); #1; n++; end
  endtask
  // wait is the bench's 20-cycle delay plus the post-reset periods
  task waitRun;
    waitCpu; expMode = 4;
    `CHK(n >= 20 + `POST_RESET_CYC && n <= 25 + `POST_RESET_CYC, 1'b1, "start delay")
    `CHK({ramPageSelect, directPageFlag, supplyDropMonitorEn, boosterEn}, 11'h0, "init")
    `CHK(vectorAddr, `RESET_VECTOR_LO, "vector")
    rd(`ADDR_POWER_DOWN_CONTROL, 8'h00);
    rd(`ADDR_CLOCK_MODE_SELECT, 8'h00);
  endtask
  // compare clock gating and status with the mode model, off the edge
  task chkMode;
    #1;
    `CHK(cpuClkEn, expMode == 4, "cpu clock")
    `CHK(periClkEn, expMode != 16, "peripheral clock")
    `CHK(mainOscEn, expMode != 16, "main osc")
    `CHK({subOscEn, watchClkEn, boosterClkEn}, 3'b111, "sub clocks")
    rd(`ADDR_STATUS, expMode[7:0]);
  endtask
  task stopEnter;
    wr(`ADDR_POWER_DOWN_CONTROL, `CODE_STOP_UNLOCK);
    execStop <= 1'b1;
    tick(1);
    execStop <= 1'b0;
    tick(3);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 0; regWrite = 0; regRead = 0; regAddr = 0; regWrData = 0; resetPinN = 1;
    watchdogReset = 0; oscStable = 1; extClockUsed = 0; anyIrqPending = 0; execStop = 0;
    wakeRequest = 0; wakeEnable = 0; eventCounterMode = 0;
    v = $urandom(32'ha085);
    tick(6); rst_n <= 1'b1; waitRun;
    rd(8'he0, 8'h00);
    v = 8'h60 | ($urandom % 32);
    wr(`ADDR_POWER_DOWN_CONTROL, v); rd(`ADDR_POWER_DOWN_CONTROL, v);
    execStop <= 1'b1; tick(1); execStop <= 1'b0; tick(3); chkMode;
    extClockUsed <= 1'b1; stopEnter; chkMode; extClockUsed <= 1'b0;
    wr(`ADDR_POWER_DOWN_CONTROL, `CODE_SLEEP); expMode = 8;
    wakeRequest <= 4'hf; tick(3); chkMode;
    anyIrqPending <= 1'b1; tick(1); anyIrqPending <= 1'b0; wakeRequest <= 4'h0;
    tick(3); expMode = 4; chkMode;
    foreach (srcQ[i]) begin
      v = $urandom; eventCounterMode <= v[1:0];
      // a random mode value must survive the stop wake
      wr(`ADDR_CLOCK_MODE_SELECT, v);
      // zero keeps the full minimum start-up count before stop
      wr(`ADDR_INTERVAL_TIMER_CTL, 8'h00);
      stopEnter; expMode = 16; chkMode;
      `CHK(timerRun, eventCounterMode, "timers")
      `CHK({mainOscInputTieLow, intervalTimerRun, retainState}, 3'b101, "stop pins")
      wakeRequest <= 4'h1 << srcQ[i]; wakeEnable <= ~(4'h1 << srcQ[i]); anyIrqPending <= 1'b1;
      tick(4); chkMode;
      anyIrqPending <= 1'b0; wakeEnable <= 4'hf; tick(1); waitCpu;
      `CHK(n >= 10 && n <= 15, 1'b1, "start-up")
      wakeRequest <= 4'h0; wakeEnable <= 4'h0; expMode = 4; chkMode;
      rd(`ADDR_CLOCK_MODE_SELECT, v);
      `CHK(ctrlRegInit, 1'b0, "wake kept registers")
    end
    resetPinN <= 1'b0; tick(190); resetPinN <= 1'b1; tick(3);
    `CHK(cpuRun, 1'b1, "short pin pulse")
    oscStable <= 1'b0; resetPinN <= 1'b0; tick(210); resetPinN <= 1'b1; oscStable <= 1'b1;
    tick(3); `CHK(cpuRun, 1'b1, "unstable pin pulse")
    stopEnter; resetPinN <= 1'b0; tick(210);
    `CHK(ctrlRegInit, 1'b1, "pin reset")
    resetPinN <= 1'b1; waitRun;
    // a non-zero mode value shows that the watchdog reinitialises too
    wr(`ADDR_CLOCK_MODE_SELECT, 8'h3c);
    watchdogReset <= 1'b1; tick(3); `CHK(ctrlRegInit, 1'b1, "watchdog")
    watchdogReset <= 1'b0; waitRun;
    summarize;
  end
endmodule

// ==== testbench/pwr_cpu_partner.sv ====
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// cpu core: turns a stop request into one instruction pulse
module pwr_cpu_partner (
  input  wire core_clk,
  input  wire rst_n,
  input  wire cpuRun,
  input  wire execStop,
  output reg  stopInstr
);
  // only a running cpu executes; feedback from stopInstr keeps pulses apart
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) stopInstr <= 1'b0;
    else stopInstr <= execStop && cpuRun && !stopInstr;
  end
endmodule

// ==== testbench/pwr_seq_props.sv ====
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// watches the sequencer ports only
module pwr_seq_props (
  input wire       core_clk,
  input wire       rst_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrite,
  input wire       anyIrqPending,
  input wire       resetPinN,
  input wire       watchdogReset,
  input wire [3:0] wakeRequest,
  input wire [3:0] wakeEnable,
  input wire [1:0] eventCounterMode,
  input wire       cpuClkEn,
  input wire       cpuRun,
  input wire       periClkEn,
  input wire       mainOscEn,
  input wire       mainOscInputTieLow,
  input wire       intervalTimerRun,
  input wire [1:0] timerRun,
  input wire       retainState,
  input wire       ctrlRegInit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // main oscillator off outside reset marks stop
  wire stopped = !mainOscEn && !ctrlRegInit;
  wire wakeHit = (wakeRequest & wakeEnable) != 4'h0;
  reg  asleep_ff;  // a sleep write was taken and the cpu has not run since
  // sleep and the post-reset wait look alike on the ports, so track the write
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep_ff <= 1'b0;
    end else if (cpuRun && regWrite && regAddr == `ADDR_POWER_DOWN_CONTROL
                 && regWrData == `CODE_SLEEP) begin
      asleep_ff <= 1'b1;
    end else if (cpuRun || ctrlRegInit) begin
      asleep_ff <= 1'b0;
    end
  end
  sequence s_irqWake;
    anyIrqPending && resetPinN && !watchdogReset;
  endsequence
  sequence s_sleepWrite;
    cpuRun && regWrite && regAddr == `ADDR_POWER_DOWN_CONTROL && regWrData == `CODE_SLEEP;
  endsequence
  sequence s_quiet;
    !anyIrqPending && resetPinN && !watchdogReset;
  endsequence
  property p_sleepHold;
    s_sleepWrite ##1 s_quiet [*4] |-> !cpuClkEn && periClkEn && mainOscEn;
  endproperty
  a_sleepHold: assert property (p_sleepHold) else $error("sleep not held");
  property p_sleepWake;
    asleep_ff && !cpuRun && !ctrlRegInit && s_irqWake |=> cpuRun;
  endproperty
  a_sleepWake: assert property (p_sleepWake) else $error("sleep not woken");
  property p_stopClocks;
    stopped |-> !periClkEn && !cpuClkEn && mainOscInputTieLow && !intervalTimerRun && retainState;
  endproperty
  a_stopClocks: assert property (p_stopClocks) else $error("stop outputs wrong");
  property p_stopTimers;
    stopped ##1 stopped |-> timerRun == $past(eventCounterMode);
  endproperty
  a_stopTimers: assert property (p_stopTimers) else $error("stop timers wrong");
  property p_stopHold;
    stopped && !wakeHit && resetPinN && !watchdogReset |=> !mainOscEn;
  endproperty
  a_stopHold: assert property (p_stopHold) else $error("stop left early");
  property p_stopWake;
    stopped && wakeHit |-> ##[1:2] (mainOscEn && !cpuRun);
  endproperty
  a_stopWake: assert property (p_stopWake) else $error("stop not woken");
  property p_startupHalt;
    $rose(mainOscEn) && !ctrlRegInit |-> !cpuRun [*8];
  endproperty
  a_startupHalt: assert property (p_startupHalt) else $error("start-up too short");
  property p_watchdog;
    watchdogReset |-> ##[1:2] (ctrlRegInit && !cpuRun && !cpuClkEn);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog reset missed");
  property p_resetState;
    ctrlRegInit |-> !cpuRun && periClkEn;
  endproperty
  a_resetState: assert property (p_resetState) else $error("reset state wrong");
endmodule
bind power_down_and_reset_sequencer pwr_seq_props u_props (.core_clk(core_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .resetPinN(resetPinN),
  .anyIrqPending(anyIrqPending), .watchdogReset(watchdogReset), .wakeRequest(wakeRequest),
  .wakeEnable(wakeEnable), .eventCounterMode(eventCounterMode), .cpuClkEn(cpuClkEn),
  .cpuRun(cpuRun), .periClkEn(periClkEn), .mainOscEn(mainOscEn), .timerRun(timerRun),
  .mainOscInputTieLow(mainOscInputTieLow), .intervalTimerRun(intervalTimerRun),
  .retainState(retainState), .ctrlRegInit(ctrlRegInit));
